// ===== core/fic_pkg.sv
// Shared constants and types for the faceplate indicator control block.
package fic_pkg;

	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned BLINK_HALF_MS  = 250;
	localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;

	localparam int unsigned SUPPLY_CNT  = 2;
	localparam int unsigned FLAG_W      = 4;
	localparam int unsigned FLAG_ELO    = 0;
	localparam int unsigned FLAG_LO     = 1;
	localparam int unsigned FLAG_HI     = 2;
	localparam int unsigned FLAG_EHI    = 3;
	localparam int unsigned SYNC_W      = SUPPLY_CNT * FLAG_W + 1;
	localparam int unsigned SYNC_BTN    = SYNC_W - 1;

	localparam logic LAMP_ON  = 1'b1;
	localparam logic LAMP_OFF = 1'b0;

	typedef enum logic {
		FIC_ACO_IDLE,
		FIC_ACO_CUTOFF
	} fic_aco_state_t;

endpackage

// ===== core/fic_supply_if.sv
// Interface carrying one supply input's comparator flags and lamp colour.
`timescale 1ns/1ps
`default_nettype none
interface fic_supply_if;
	logic [fic_pkg::FLAG_W-1:0] flags;
	logic                       intl;
	logic                       green;
	logic                       red;

	modport decoder (
		input  flags,
		input  intl,
		output green,
		output red
	);

	modport owner (
		output flags,
		output intl,
		input  green,
		input  red
	);
endinterface
`default_nettype wire

// ===== core/fic_supply_decode.sv
// Supply lamp colour decoder for one supply input.
`timescale 1ns/1ps
`default_nettype none
module fic_supply_decode (
	fic_supply_if.decoder sup
);
	logic extreme;
	logic band;

	// Amber shows as green and red together on a bicolour lamp.
	always_comb begin
		extreme = sup.flags[fic_pkg::FLAG_EHI] | sup.flags[fic_pkg::FLAG_ELO];
		band    = sup.flags[fic_pkg::FLAG_HI] | sup.flags[fic_pkg::FLAG_LO];
		if (extreme) begin // [R15]
			sup.green = fic_pkg::LAMP_OFF;
			sup.red   = fic_pkg::LAMP_ON;
		end else if (sup.intl) begin // [R16]
			sup.green = fic_pkg::LAMP_ON;
			sup.red   = fic_pkg::LAMP_OFF;
		end else if (band) begin // [R14]
			sup.green = fic_pkg::LAMP_ON;
			sup.red   = fic_pkg::LAMP_ON;
		end else begin // [R13]
			sup.green = fic_pkg::LAMP_ON;
			sup.red   = fic_pkg::LAMP_OFF;
		end
	end
endmodule
`default_nettype wire

// ===== core/fic_faceplate.sv
// Faceplate indicator control: card, network and supply lamps with cutoff.
// Notes on behaviour
// [R01] Fault lamp lit throughout card reset.
// [R02] Fault lamp flashes while booting or writing.
// [R03] Role lamp green if active, amber if standby.
// [R04] Card lamps blink during active database writes.
// [R05] Top severity lamp on with critical alarm.
// [R06] Second severity lamp on with major alarm.
// [R07] Third severity lamp on with minor alarm.
// [R08] Far-site lamp red on any remote alarm.
// [R09] Timing lamp green only when externally locked.
// [R10] Button press lights silence lamp, opens contact.
// [R11] New alarm cancels an active cutoff.
// [R12] Cleared alarm returns cutoff to idle.
// [R13] Supply lamp green between low and high.
// [R14] Supply lamp amber in the outer bands.
// [R15] Supply lamp red beyond the extreme thresholds.
// [R16] International shelf: green inside extremes, else red.
// [R17] Lamp colour decoded from four comparator flags.
// [R18] One shared divider drives every blink pattern.
`timescale 1ns/1ps
`default_nettype none
module fic_faceplate #(
	parameter int unsigned BLINK_HALF_CYC = fic_pkg::BLINK_HALF_CYC
) (
	input  wire logic                        clk_sys,
	input  wire logic                        nrst,
	input  wire logic                        card_booting,
	input  wire logic                        db_writing,
	input  wire logic                        card_active,
	input  wire logic                        alarm_top_severity_lamp,
	input  wire logic                        alarm_maj,
	input  wire logic                        alarm_min,
	input  wire logic                        alarm_remote,
	input  wire logic                        alarm_new,
	input  wire logic                        timing_locked,
	input  wire logic                        intl_shelf,
	input  wire logic                        silence_button,
	input  wire logic [fic_pkg::FLAG_W-1:0]  supply_one_flags,
	input  wire logic [fic_pkg::FLAG_W-1:0]  supply_two_flags,
	output logic                             card_fault_lamp,
	output logic                             role_lamp_green,
	output logic                             role_lamp_amber,
	output logic                             top_severity_lamp,
	output logic                             second_severity_lamp,
	output logic                             third_severity_lamp,
	output logic                             far_site_alarm_lamp,
	output logic                             timing_lock_lamp,
	output logic                             alarm_silence_lamp,
	output logic                             audible_alarm_closed,
	output logic                             supply_one_lamp_green,
	output logic                             supply_one_lamp_red,
	output logic                             supply_two_lamp_green,
	output logic                             supply_two_lamp_red
);

	// Pins from the faceplate and the analog monitor cross into clk_sys.
	logic [fic_pkg::SYNC_W-1:0] sync1_r;
	logic [fic_pkg::SYNC_W-1:0] sync2_r;
	logic                       btn_prev_r;
	logic                       btn_prev_nxt;
	logic                       btn_rise;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync1_r    <= '0;
			sync2_r    <= '0;
			btn_prev_r <= 1'b0;
		end else begin
			sync1_r    <= {silence_button, supply_two_flags, supply_one_flags};
			sync2_r    <= sync1_r;
			btn_prev_r <= btn_prev_nxt;
		end
	end

	always_comb begin
		btn_prev_nxt = sync2_r[fic_pkg::SYNC_BTN];
		btn_rise     = sync2_r[fic_pkg::SYNC_BTN] & ~btn_prev_r;
	end

	// Shared blink divider; one phase keeps all flashing lamps in step.
	logic [31:0] blink_cnt_r;
	logic [31:0] blink_cnt_nxt;
	logic        blink_r;
	logic        blink_nxt;

	always_comb begin
		blink_cnt_nxt = blink_cnt_r + 32'h0000_0001;
		blink_nxt     = blink_r;
		if (blink_cnt_r >= BLINK_HALF_CYC - 1) begin // [R18]
			blink_cnt_nxt = '0;
			blink_nxt     = ~blink_r;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else begin
			blink_cnt_r <= blink_cnt_nxt;
			blink_r     <= blink_nxt;
		end
	end

	// Alarm cutoff. A new alarm beats a press in the same cycle, so
	// a fresh alarm is never silenced by a press that raced it.
	fic_pkg::fic_aco_state_t aco_r;
	fic_pkg::fic_aco_state_t aco_nxt;
	logic                    local_any;

	always_comb begin
		local_any = alarm_top_severity_lamp | alarm_maj | alarm_min;
		aco_nxt   = aco_r;
		case (aco_r)
			fic_pkg::FIC_ACO_IDLE: begin
				if (btn_rise && local_any && !alarm_new) begin // [R10]
					aco_nxt = fic_pkg::FIC_ACO_CUTOFF;
				end
			end
			fic_pkg::FIC_ACO_CUTOFF: begin
				if (alarm_new) begin // [R11]
					aco_nxt = fic_pkg::FIC_ACO_IDLE;
				end else if (!local_any) begin // [R12]
					aco_nxt = fic_pkg::FIC_ACO_IDLE;
				end
			end
			default: begin
				aco_nxt = fic_pkg::FIC_ACO_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			aco_r <= fic_pkg::FIC_ACO_IDLE;
		end else begin
			aco_r <= aco_nxt;
		end
	end

	// Supply colour decoders, one per supply input.
	logic [fic_pkg::SUPPLY_CNT-1:0] sup_green;
	logic [fic_pkg::SUPPLY_CNT-1:0] sup_red;

	genvar gi;
	generate
		for (gi = 0; gi < fic_pkg::SUPPLY_CNT; gi++) begin : g_sup
			fic_supply_if sup ();
			assign sup.flags = sync2_r[gi*fic_pkg::FLAG_W +: fic_pkg::FLAG_W]; // [R17]
			assign sup.intl  = intl_shelf;
			assign sup_green[gi] = sup.green;
			assign sup_red[gi]   = sup.red;
			fic_supply_decode u_dec (
				.sup (sup)
			);
		end
	endgenerate

	// Lamp registers; every faceplate output comes straight from here.
	logic card_fault_nxt;
	logic role_green_nxt;
	logic role_amber_nxt;
	logic role_lit;
	logic flash_card;

	always_comb begin
		flash_card     = card_active & db_writing;
		card_fault_nxt = fic_pkg::LAMP_OFF;
		if (card_booting || db_writing || flash_card) begin // [R02] [R04]
			card_fault_nxt = blink_r;
		end
		role_lit = flash_card ? blink_r : fic_pkg::LAMP_ON; // [R04]
		role_green_nxt = card_active & role_lit; // [R03]
		role_amber_nxt = ~card_active & role_lit; // [R03]
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			card_fault_lamp       <= fic_pkg::LAMP_ON; // [R01]
			role_lamp_green       <= fic_pkg::LAMP_OFF;
			role_lamp_amber       <= fic_pkg::LAMP_OFF;
			top_severity_lamp     <= fic_pkg::LAMP_OFF;
			second_severity_lamp  <= fic_pkg::LAMP_OFF;
			third_severity_lamp   <= fic_pkg::LAMP_OFF;
			far_site_alarm_lamp   <= fic_pkg::LAMP_OFF;
			timing_lock_lamp      <= fic_pkg::LAMP_OFF;
			alarm_silence_lamp    <= fic_pkg::LAMP_OFF;
			audible_alarm_closed  <= fic_pkg::LAMP_OFF;
			supply_one_lamp_green <= fic_pkg::LAMP_OFF;
			supply_one_lamp_red   <= fic_pkg::LAMP_OFF;
			supply_two_lamp_green <= fic_pkg::LAMP_OFF;
			supply_two_lamp_red   <= fic_pkg::LAMP_OFF;
		end else begin
			card_fault_lamp       <= card_fault_nxt;
			role_lamp_green       <= role_green_nxt;
			role_lamp_amber       <= role_amber_nxt;
			top_severity_lamp     <= alarm_top_severity_lamp; // [R05]
			second_severity_lamp  <= alarm_maj; // [R06]
			third_severity_lamp   <= alarm_min; // [R07]
			far_site_alarm_lamp   <= alarm_remote; // [R08]
			timing_lock_lamp      <= timing_locked; // [R09]
			alarm_silence_lamp    <= aco_nxt == fic_pkg::FIC_ACO_CUTOFF; // [R10]
			audible_alarm_closed  <= local_any &&
				aco_nxt != fic_pkg::FIC_ACO_CUTOFF; // [R10] [R11]
			supply_one_lamp_green <= sup_green[0];
			supply_one_lamp_red   <= sup_red[0];
			supply_two_lamp_green <= sup_green[1];
			supply_two_lamp_red   <= sup_red[1];
		end
	end

	// Checks, all on clk_sys.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	logic [fic_pkg::FLAG_W-1:0] f1;
	logic [fic_pkg::FLAG_W-1:0] f2;
	assign f1 = sync2_r[fic_pkg::FLAG_W-1:0];
	assign f2 = sync2_r[fic_pkg::FLAG_W +: fic_pkg::FLAG_W];

	a_fault_boot_flash: assert property ( // [R02]
		card_booting |=> card_fault_lamp == $past(blink_r))
		else $error("fault lamp not following blink while booting");

	a_fault_idle_dark: assert property ( // [R02]
		!card_booting && !db_writing |=> !card_fault_lamp)
		else $error("fault lamp lit with no boot or write");

	a_role_write_blink: assert property ( // [R04]
		card_active && db_writing |=>
		role_lamp_green == $past(blink_r) && !role_lamp_amber)
		else $error("role lamp not blinking during write");

	a_role_colour: assert property ( // [R03]
		!db_writing |=> role_lamp_green == $past(card_active) &&
		role_lamp_amber == !$past(card_active))
		else $error("role lamp colour wrong");

	a_severity_lamps: assert property ( // [R05]
		1'b1 |=> top_severity_lamp == $past(alarm_top_severity_lamp) &&
		second_severity_lamp == $past(alarm_maj) &&
		third_severity_lamp == $past(alarm_min))
		else $error("severity lamp mismatch");

	a_far_site_lamp: assert property ( // [R08]
		1'b1 |=> far_site_alarm_lamp == $past(alarm_remote))
		else $error("far-site lamp not following remote alarm");

	a_timing_lamp: assert property ( // [R09]
		1'b1 |=> timing_lock_lamp == $past(timing_locked))
		else $error("timing lamp not following lock state");

	a_press_refused: assert property ( // [R10]
		!alarm_silence_lamp && !local_any |=> !alarm_silence_lamp)
		else $error("cutoff entered with no local alarm");

	a_press_silence: assert property ( // [R10]
		btn_rise && local_any && !alarm_new && !alarm_silence_lamp |=>
		alarm_silence_lamp && !audible_alarm_closed)
		else $error("press did not enter cutoff");

	a_cutoff_cancel: assert property ( // [R11]
		alarm_silence_lamp && alarm_new && local_any |=>
		!alarm_silence_lamp && audible_alarm_closed)
		else $error("new alarm did not cancel cutoff");

	a_cutoff_clear: assert property ( // [R12]
		alarm_silence_lamp && !local_any |=>
		!alarm_silence_lamp && !audible_alarm_closed)
		else $error("cutoff not reset after alarm cleared");

	a_supply_red: assert property ( // [R15]
		(f1[fic_pkg::FLAG_EHI] || f1[fic_pkg::FLAG_ELO]) |=>
		supply_one_lamp_red && !supply_one_lamp_green)
		else $error("supply lamp not red beyond extremes");

	a_supply_amber: assert property ( // [R14]
		!intl_shelf && f1[fic_pkg::FLAG_HI] && !f1[fic_pkg::FLAG_EHI] &&
		!f1[fic_pkg::FLAG_ELO] |=> supply_one_lamp_red && supply_one_lamp_green)
		else $error("supply lamp not amber in outer band");

	a_supply_green: assert property ( // [R13]
		!intl_shelf && f1 == '0 |=>
		supply_one_lamp_green && !supply_one_lamp_red)
		else $error("supply lamp not green inside band");

	a_supply_two_red: assert property ( // [R15]
		(f2[fic_pkg::FLAG_EHI] || f2[fic_pkg::FLAG_ELO]) |=>
		supply_two_lamp_red && !supply_two_lamp_green)
		else $error("second supply lamp not red beyond extremes");

	a_supply_intl: assert property ( // [R16]
		intl_shelf && !f1[fic_pkg::FLAG_EHI] && !f1[fic_pkg::FLAG_ELO] |=>
		supply_one_lamp_green && !supply_one_lamp_red)
		else $error("international shelf lamp not green");

	a_blink_period: assert property ( // [R18]
		$changed(blink_r) |-> blink_cnt_r == '0 &&
		$past(blink_cnt_r) == BLINK_HALF_CYC - 1)
		else $error("blink toggled off its period");

	c_cutoff_entered: cover property (
		!alarm_silence_lamp ##1 alarm_silence_lamp);
	c_cutoff_cancelled: cover property (
		alarm_silence_lamp && alarm_new ##1 audible_alarm_closed);
	c_supply_amber: cover property (
		supply_two_lamp_green && supply_two_lamp_red);
	c_fault_flash: cover property (
		card_booting && $rose(card_fault_lamp));
	c_cutoff_cleared: cover property (
		alarm_silence_lamp && !local_any ##1 !audible_alarm_closed);

endmodule
`default_nettype wire

// ===== verif/fic_panel_model.sv
// Panel model: alarm-cutoff pushbutton and supply voltage monitor.
`timescale 1ns/1ps
`default_nettype none
module fic_panel_model (
	input  wire logic                       press,
	input  wire logic [2:0]                 band_one,
	input  wire logic [2:0]                 band_two,
	output logic                            silence_button,
	output logic [fic_pkg::FLAG_W-1:0]      supply_one_flags,
	output logic [fic_pkg::FLAG_W-1:0]      supply_two_flags
);
	// Band 0 is the lowest voltage and 4 the highest.
	// A supply beyond an extreme threshold is also beyond the milder one.
	// The monitor raises both flags together, as a real comparator pair does.
	function automatic logic [fic_pkg::FLAG_W-1:0] enc(input logic [2:0] b);
		case (b)
			3'h0:    return 4'h3;
			3'h1:    return 4'h2;
			3'h3:    return 4'h4;
			3'h4:    return 4'hc;
			default: return 4'h0;
		endcase
	endfunction
	assign silence_button   = press;
	assign supply_one_flags = enc(band_one);
	assign supply_two_flags = enc(band_two);
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the faceplate indicator control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin \
	$display("[ERR] t=%0t got %h exp %h", $time, a, e); fails++; end end
module tb_top;
	localparam int unsigned HALF = 8;
	logic       clk_sys      = 1'b0;
	logic       nrst         = 1'b0;
	logic       card_booting = 1'b0;
	logic       db_writing   = 1'b0;
	logic       card_active  = 1'b0;
	logic       alarm_top_severity_lamp   = 1'b0;
	logic       alarm_maj    = 1'b0;
	logic       alarm_min    = 1'b0;
	logic       alarm_remote = 1'b0;
	logic       alarm_new    = 1'b0;
	logic       timing_locked = 1'b0;
	logic       intl_shelf   = 1'b0;
	logic       press        = 1'b0;
	logic [2:0] band_one     = 3'h2;
	logic [2:0] band_two     = 3'h2;
	logic       silence_button;
	logic [3:0] supply_one_flags;
	logic [3:0] supply_two_flags;
	logic       card_fault_lamp, role_lamp_green, role_lamp_amber;
	logic       top_severity_lamp, second_severity_lamp, third_severity_lamp;
	logic       far_site_alarm_lamp, timing_lock_lamp, alarm_silence_lamp;
	logic       audible_alarm_closed;
	logic       supply_one_lamp_green, supply_one_lamp_red;
	logic       supply_two_lamp_green, supply_two_lamp_red;
	logic [13:0] all_out;
	logic [1:0] exp_n [5] = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h1};
	logic [1:0] exp_i [5] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h1};
	logic       a;
	int         fails   = 0;
	int         n_tests = 0;

	assign all_out = {card_fault_lamp, role_lamp_green, role_lamp_amber,
		top_severity_lamp, second_severity_lamp, third_severity_lamp,
		far_site_alarm_lamp, timing_lock_lamp, alarm_silence_lamp,
		audible_alarm_closed, supply_one_lamp_green, supply_one_lamp_red,
		supply_two_lamp_green, supply_two_lamp_red};

	always #2.5 clk_sys = ~clk_sys;

	// A short blink period keeps the run small; expectations follow HALF.
	fic_faceplate #(.BLINK_HALF_CYC(HALF)) DUT (
		.clk_sys, .nrst, .card_booting, .db_writing, .card_active,
		.alarm_top_severity_lamp, .alarm_maj, .alarm_min, .alarm_remote, .alarm_new,
		.timing_locked, .intl_shelf, .silence_button, .supply_one_flags,
		.supply_two_flags, .card_fault_lamp, .role_lamp_green,
		.role_lamp_amber, .top_severity_lamp, .second_severity_lamp,
		.third_severity_lamp, .far_site_alarm_lamp, .timing_lock_lamp,
		.alarm_silence_lamp, .audible_alarm_closed, .supply_one_lamp_green,
		.supply_one_lamp_red, .supply_two_lamp_green, .supply_two_lamp_red
	);

	fic_panel_model PANEL (
		.press, .band_one, .band_two, .silence_button,
		.supply_one_flags, .supply_two_flags
	);

	task automatic step(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic end_of_test();
		if (fails == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		step(20);
		`CHK(all_out, 14'h2000)
		nrst = 1'b1;
		for (int i = 0; i < 5; i++) begin
			{alarm_top_severity_lamp, alarm_maj, alarm_min, alarm_remote,
				timing_locked} = 5'h1 << i;
			step(2);
			`CHK(all_out[10:6], 5'h1 << i)
		end
		{alarm_top_severity_lamp, alarm_maj, alarm_min, alarm_remote,
			timing_locked} = 5'h0;
		card_booting = 1'b1;
		step(2);
		a = card_fault_lamp;
		step(HALF);
		`CHK(card_fault_lamp, ~a)
		card_booting = 1'b0;
		db_writing = 1'b1;
		card_active = 1'b1;
		step(2);
		a = role_lamp_green;
		step(HALF);
		`CHK(role_lamp_green, ~a)
		`CHK(card_fault_lamp, ~a)
		db_writing = 1'b0;
		step(2);
		`CHK({role_lamp_green, role_lamp_amber}, 2'h2)
		card_active = 1'b0;
		step(2);
		`CHK({role_lamp_green, role_lamp_amber}, 2'h1)
		// Both supplies move in opposite directions through every band.
		for (int s = 0; s < 2; s++) begin
			intl_shelf = s[0];
			for (int b = 0; b < 5; b++) begin
				band_one = 3'(b);
				band_two = 3'(4 - b);
				step(4);
				`CHK({supply_one_lamp_green, supply_one_lamp_red},
					s ? exp_i[b] : exp_n[b])
				`CHK({supply_two_lamp_green, supply_two_lamp_red},
					s ? exp_i[4-b] : exp_n[4-b])
			end
		end
		press = 1'b1;
		step(5);
		press = 1'b0;
		`CHK({alarm_silence_lamp, audible_alarm_closed}, 2'h0)
		alarm_maj = 1'b1;
		step(2);
		`CHK({alarm_silence_lamp, audible_alarm_closed}, 2'h1)
		press = 1'b1;
		step(5);
		`CHK({alarm_silence_lamp, audible_alarm_closed}, 2'h2)
		alarm_new = 1'b1;
		step(1);
		alarm_new = 1'b0;
		step(1);
		`CHK({alarm_silence_lamp, audible_alarm_closed}, 2'h1)
		// The button is still held, so no second cutoff may start.
		step(4);
		`CHK({alarm_silence_lamp, audible_alarm_closed}, 2'h1)
		press = 1'b0;
		step(4);
		press = 1'b1;
		step(5);
		`CHK({alarm_silence_lamp, audible_alarm_closed}, 2'h2)
		alarm_maj = 1'b0;
		step(2);
		`CHK({alarm_silence_lamp, audible_alarm_closed}, 2'h0)
		press = 1'b0;
		nrst = 1'b0;
		step(1);
		`CHK(all_out, 14'h2000)
		nrst = 1'b1;
		step(2);
		`CHK(card_fault_lamp, 1'b0)
		end_of_test();
	end
endmodule
`default_nettype wire
